// File: rtl/lnb_defs.svh
`ifndef LNB_DEFS_SVH
`define LNB_DEFS_SVH

// System clock and derived timing
`define LNB_CLK_HZ 50000000
`define LNB_TONE_HZ 22000
`define LNB_TONE_HALF_CYCLES (`LNB_CLK_HZ / (2 * `LNB_TONE_HZ))
`define LNB_TICK_MS 1
`define LNB_TICK_CYCLES (`LNB_CLK_HZ / 1000 * `LNB_TICK_MS)
`define LNB_RETRY_OFF_MS 900
`define LNB_RETRY_ON_MS 20
`define LNB_RETRY_OFF_TICKS (`LNB_RETRY_OFF_MS / `LNB_TICK_MS)
`define LNB_RETRY_ON_TICKS (`LNB_RETRY_ON_MS / `LNB_TICK_MS)
`define LNB_SCL_HZ 100000
`define LNB_SCL_QUARTER_CYCLES (`LNB_CLK_HZ / (4 * `LNB_SCL_HZ))

// Bus address: upper six bits fixed, then strap bit, then read/write
`define LNB_ADDR_HIGH 6'h04

// Register byte layout
`define LNB_SEL_BIT 7
`define LNB_R1_STATIC_BIT 6
`define LNB_R1_THRESH_BIT 5
`define LNB_R1_FORCE_BIT 4
`define LNB_R1_COMP_BIT 3
`define LNB_R1_HIGH_BIT 2
`define LNB_R1_ON_BIT 1
`define LNB_R1_OVERLOAD_BIT 0
`define LNB_R2_THRESH_BIT 6
`define LNB_R2_FORCE_BIT 5
`define LNB_R2_COMP_BIT 4
`define LNB_R2_HIGH_BIT 3
`define LNB_R2_ON_BIT 2
`define LNB_R2_OVERHEAT_BIT 1
`define LNB_R2_OVERLOAD_BIT 0
`define LNB_R1_WR_MASK 8'h7e
`define LNB_R2_WR_MASK 8'h7c
`define LNB_REG_RESET 8'h00

// Host command port offsets and fields
`define LNB_HOST_CMD 2'h0
`define LNB_HOST_TXDATA 2'h1
`define LNB_HOST_RXDATA 2'h2
`define LNB_HOST_STATUS 2'h3
`define LNB_CMD_READ_BIT 0
`define LNB_CMD_ADDR_BIT 1
`define LNB_ACK_SLOT 5'h08
`define LNB_LAST_SLOT 5'h11

`endif

// File: rtl/lnb_pkg.sv
package lnb_pkg;

  // Slave byte engine states
  typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_SKIP} lnb_i2c_state_type;

  // Dynamic current-limit retry states
  typedef enum logic [1:0] {RETRY_IDLE, RETRY_OFF, RETRY_ON} lnb_retry_type;

  // Master sequencer phases
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} lnb_host_phase_type;

  // Whole state of the device end
  typedef struct packed {
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic sclPrev;
    logic sdaPrev;
    logic ssPrev;
    lnb_i2c_state_type i2cState;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic isAddr;
    logic isRead;
    logic regSel;
    logic sdaOe;
    logic [7:0] cfgOne;
    logic [7:0] cfgTwo;
    logic [1:0] overload;
    logic overheat;
    lnb_retry_type [1:0] retry;
    logic [1:0][15:0] retryCnt;
    logic [1:0] onSeen;
    logic [15:0] tickCnt;
    logic tick;
    logic [15:0] toneCnt;
    logic tonePhase;
    logic [1:0] convOn;
    logic [1:0] voltHigh;
    logic [1:0] cableComp;
    logic [1:0] limitHigh;
    logic [1:0] toneOut;
    logic limitStatic;
  } lnb_dev_regs_type;

  // Whole state of the host end
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    lnb_host_phase_type phase;
    logic [15:0] qCnt;
    logic [1:0] quarter;
    logic [4:0] slot;
    logic rw;
    logic addrSel;
    logic [7:0] txData;
    logic [7:0] rxData;
    logic busy;
    logic nack;
    logic done;
    logic sclOe;
    logic sdaOe;
    logic [7:0] rdata;
  } lnb_host_regs_type;

endpackage

// File: rtl/lnb_if.sv
`timescale 1ns/10ps
// Open-drain two-wire bus between controller and supply
interface lnb_if;
  logic hostSclOut; // Host clock drive value
  logic hostSclOe; // Host pulls clock
  logic hostSdaOut; // Host data drive value
  logic hostSdaOe; // Host pulls data
  logic devSdaOut; // Device data drive value
  logic devSdaOe; // Device pulls data
  logic scl; // Resolved clock wire
  logic sda; // Resolved data wire

  // Wired-AND with pull-ups
  assign scl = !(hostSclOe && !hostSclOut);
  assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

  modport device (input scl, input sda, output devSdaOut, output devSdaOe);
  modport host (input scl, input sda, output hostSclOut, output hostSclOe,
    output hostSdaOut, output hostSdaOe);
endinterface

// File: rtl/lnb_device.sv
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "lnb_defs.svh"
// How it works
// R1: Tone force gives continuous tone, gate ignored
// R2: Without force, gate pin switches tone
// R3: Host keeps force low when gating bursts
// R4: Disabled channel turns off its converter only
// R5: Select bit picks 13V or 18V
// R6: Compensation bit adds one volt
// R7: Threshold bit picks low or high limit
// R8: Dynamic overload: output off, flag set
// R9: After off time, retry on; repeat if overloaded
// R10: Clean on period restores output, clears flag
// R11: Static mode: flag follows clamp condition
// R12: Flags read zero after soft-start completes; code clears overload flags only; one raised that cycle survives
// R13: Host starts capacitive loads in static mode
// R14: Overheat shuts off, sets flag, clears registers
// R15: Force-high pin overrides select to high voltage
// R16: Host programs 13V when using force pins
// R17: No acknowledge while power-good is low
// R18: Start, address, ack, one byte, ack, stop
// R19: Flag bits read-only, others read-write
// R20: Registers clear to zero at reset
// R21: Eight bits, MSB first, receiver acks low
// R22: Master sends stop before each start
// R23: Written MSB selects target register
module lnb_device #(
  parameter int TICK_CYCLES = `LNB_TICK_CYCLES,
  parameter int OFF_TICKS = `LNB_RETRY_OFF_TICKS,
  parameter int ON_TICKS = `LNB_RETRY_ON_TICKS,
  parameter int TONE_HALF = `LNB_TONE_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  lnb_if.device bus,
  input wire logic addrSel,
  input wire logic [1:0] toneGate,
  input wire logic [1:0] forceHigh,
  input wire logic [1:0] overloadDet,
  input wire logic overTemp,
  input wire logic powerGood,
  input wire logic softStartDone,
  output logic [1:0] convOn,
  output logic [1:0] voltHigh,
  output logic [1:0] cableComp,
  output logic [1:0] limitHigh,
  output logic [1:0] toneOut,
  output logic limitStatic,
  output logic overheatFlag,
  output logic [1:0] overloadFlag
);
  import lnb_pkg::*;
  localparam lnb_dev_regs_type DEV_RESET = '0; // All idle, registers zero
  lnb_dev_regs_type r; // Current state
  lnb_dev_regs_type n; // Next state
  logic [11:0] pinRaw; // Raw asynchronous pins
  logic sclS, sdaS, addrS; // Synchronised clock, data and strap
  logic [1:0] gateS, forceS, olS; // Synchronised gate, force-high and overload pins
  logic otS, pgS, ssS; // Overtemperature, power-good, soft-start done
  logic sclRise, sclFall; // Clock wire edges
  logic startSeen, stopSeen; // Start and stop conditions
  logic [7:0] regOneView, regTwoView, readByte; // Registers as read, byte returned
  logic [1:0] chOn, chHigh, chComp, chForce, chThresh; // Per-channel control fields
  logic staticMode; // Shared static limit mode
  // Gather pins for the two-stage synchroniser
  assign pinRaw = {softStartDone, powerGood, overTemp, overloadDet, forceHigh, toneGate,
    addrSel, bus.sda, bus.scl};
  assign {ssS, pgS, otS, olS, forceS, gateS, addrS, sdaS, sclS} = r.sync2;

  // Bus events from synchronised levels
  assign sclRise = !r.sclPrev && sclS;
  assign sclFall = r.sclPrev && !sclS;
  assign startSeen = sclS && r.sclPrev && r.sdaPrev && !sdaS;
  assign stopSeen = sclS && r.sclPrev && !r.sdaPrev && sdaS;

  // Register views with read-only flags merged in
  assign regOneView = r.cfgOne | {7'h00, r.overload[0]}; // R19
  assign regTwoView = r.cfgTwo | {1'b1, 5'h00, r.overheat, r.overload[1]}; // R19
  assign readByte = r.regSel ? regTwoView : regOneView;

  // Per-channel control fields
  assign chOn = {r.cfgTwo[`LNB_R2_ON_BIT], r.cfgOne[`LNB_R1_ON_BIT]};
  assign chHigh = {r.cfgTwo[`LNB_R2_HIGH_BIT], r.cfgOne[`LNB_R1_HIGH_BIT]};
  assign chComp = {r.cfgTwo[`LNB_R2_COMP_BIT], r.cfgOne[`LNB_R1_COMP_BIT]};
  assign chForce = {r.cfgTwo[`LNB_R2_FORCE_BIT], r.cfgOne[`LNB_R1_FORCE_BIT]};
  assign chThresh = {r.cfgTwo[`LNB_R2_THRESH_BIT], r.cfgOne[`LNB_R1_THRESH_BIT]};
  assign staticMode = r.cfgOne[`LNB_R1_STATIC_BIT];

  // Next-state logic for the whole block
  always_comb begin
    n = r;
    n.sync1 = pinRaw;
    n.sync2 = r.sync1;
    n.sclPrev = sclS;
    n.sdaPrev = sdaS;
    n.ssPrev = ssS;

    // Millisecond tick for retry timing
    n.tick = 1'b0;
    if (r.tickCnt == 16'(TICK_CYCLES - 1)) begin
      n.tickCnt = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.tickCnt = r.tickCnt + 16'h0001;
    end

    // Tone oscillator, one half period per count
    if (r.toneCnt == 16'(TONE_HALF - 1)) begin
      n.toneCnt = 16'h0000;
      n.tonePhase = !r.tonePhase;
    end else begin
      n.toneCnt = r.toneCnt + 16'h0001;
    end

    // Slave byte engine; start and stop override any state
    if (startSeen) begin
      n.i2cState = I2C_RX; // R18
      n.bitCnt = 4'h0;
      n.isAddr = 1'b1;
      n.sdaOe = 1'b0;
    end else if (stopSeen) begin
      n.i2cState = I2C_IDLE; // R18
      n.sdaOe = 1'b0;
    end else begin
      case (r.i2cState)
        I2C_RX: begin
          if (sclRise) begin
            n.shift = {r.shift[6:0], sdaS}; // R21
            n.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == 4'h8) begin
            if (!pgS) begin
              n.i2cState = I2C_SKIP; // R17
            end else if (r.isAddr) begin
              // Match fixed bits and strap bit
              if (r.shift[7:2] == `LNB_ADDR_HIGH && r.shift[1] == addrS) begin
                n.isRead = r.shift[0]; // R18
                n.sdaOe = 1'b1; // R21
                n.i2cState = I2C_ACK;
              end else begin
                n.i2cState = I2C_SKIP;
              end
            end else begin
              // Data byte: steer by its top bit
              n.sdaOe = 1'b1; // R21
              n.i2cState = I2C_ACK;
              n.regSel = r.shift[`LNB_SEL_BIT]; // R23
              if (!otS && r.shift[`LNB_SEL_BIT]) begin
                n.cfgTwo = r.shift & `LNB_R2_WR_MASK; // R23 R19
              end else if (!otS) begin
                n.cfgOne = r.shift & `LNB_R1_WR_MASK; // R23 R19
              end
            end
          end
        end
        I2C_ACK: begin
          if (sclFall) begin
            n.sdaOe = 1'b0;
            n.bitCnt = 4'h0;
            if (r.isAddr && r.isRead) begin
              n.shift = readByte;
              n.sdaOe = !readByte[7]; // R21
              n.i2cState = I2C_TX;
            end else if (r.isAddr) begin
              n.isAddr = 1'b0;
              n.i2cState = I2C_RX;
            end else begin
              n.i2cState = I2C_SKIP; // R18
            end
          end
        end
        I2C_TX: begin
          if (sclRise) begin
            n.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == 4'h8) begin
            n.sdaOe = 1'b0; // Release for master acknowledge
            n.i2cState = I2C_SKIP;
          end else if (sclFall) begin
            n.shift = {r.shift[6:0], 1'b0};
            n.sdaOe = !r.shift[6]; // R21
          end
        end
        I2C_SKIP: n.sdaOe = 1'b0; // Wait for stop or start
        default: n.sdaOe = 1'b0;
      endcase
    end

    // Overheat clears register data while indicated
    n.overheat = otS; // R14
    if (otS) begin
      n.cfgOne = `LNB_REG_RESET; // R14
      n.cfgTwo = `LNB_REG_RESET; // R14
    end

    // Per-channel current limit and output control
    for (int ch = 0; ch < 2; ch++) begin
      if (!chOn[ch] || otS) begin
        n.retry[ch] = RETRY_IDLE;
        n.retryCnt[ch] = 16'h0000;
      end else if (staticMode) begin
        n.retry[ch] = RETRY_IDLE;
        n.overload[ch] = olS[ch]; // R11
      end else begin
        case (r.retry[ch])
          RETRY_IDLE: begin
            if (olS[ch]) begin
              n.retry[ch] = RETRY_OFF; // R8
              n.retryCnt[ch] = 16'h0000;
              n.overload[ch] = 1'b1; // R8
            end
          end
          RETRY_OFF: begin
            if (r.tick && r.retryCnt[ch] == 16'(OFF_TICKS - 1)) begin
              n.retry[ch] = RETRY_ON; // R9
              n.retryCnt[ch] = 16'h0000;
              n.onSeen[ch] = 1'b0;
            end else if (r.tick) begin
              n.retryCnt[ch] = r.retryCnt[ch] + 16'h0001;
            end
          end
          RETRY_ON: begin
            if (olS[ch]) begin
              n.onSeen[ch] = 1'b1;
            end
            if (r.tick && r.retryCnt[ch] == 16'(ON_TICKS - 1)) begin
              n.retryCnt[ch] = 16'h0000;
              if (r.onSeen[ch] || olS[ch]) begin
                n.retry[ch] = RETRY_OFF; // R9
              end else begin
                n.retry[ch] = RETRY_IDLE; // R10
                n.overload[ch] = 1'b0; // R10
              end
            end else if (r.tick) begin
              n.retryCnt[ch] = r.retryCnt[ch] + 16'h0001;
            end
          end
          default: n.retry[ch] = RETRY_IDLE;
        endcase
      end
      n.convOn[ch] = chOn[ch] && !otS && r.retry[ch] != RETRY_OFF; // R4 R8 R14
      n.voltHigh[ch] = chHigh[ch] || forceS[ch]; // R5 R15
      n.cableComp[ch] = chComp[ch]; // R6
      n.limitHigh[ch] = chThresh[ch]; // R7
      n.toneOut[ch] = r.convOn[ch] && (chForce[ch] || gateS[ch]) && r.tonePhase; // R1 R2
    end
    n.limitStatic = staticMode;

    // End of soft-start clears overload flags; a flag raised this very cycle survives
    if (ssS && !r.ssPrev) begin
      n.overload = n.overload & ~r.overload; // R12
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= DEV_RESET; // R20
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state
  assign convOn = r.convOn;
  assign voltHigh = r.voltHigh;
  assign cableComp = r.cableComp;
  assign limitHigh = r.limitHigh;
  assign toneOut = r.toneOut;
  assign limitStatic = r.limitStatic;
  assign overheatFlag = r.overheat;
  assign overloadFlag = r.overload;
  assign bus.devSdaOe = r.sdaOe;
  assign bus.devSdaOut = 1'b0;
endmodule

// File: rtl/lnb_host.sv
`timescale 1ns/10ps
`include "lnb_defs.svh"
module lnb_host #(
  parameter int QUARTER_CYCLES = `LNB_SCL_QUARTER_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  lnb_if.host bus,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata
);
  import lnb_pkg::*;

  localparam lnb_host_regs_type HOST_RESET = '0; // Idle, bus released

  lnb_host_regs_type r; // Current state
  lnb_host_regs_type n; // Next state
  logic sclS; // Synchronised clock wire
  logic sdaS; // Synchronised data wire
  logic qTick; // Quarter bit period elapsed
  logic [7:0] addrByte; // Address byte of this transfer

  assign sclS = r.sync2[0];
  assign sdaS = r.sync2[1];
  assign qTick = (r.qCnt == 16'(QUARTER_CYCLES - 1));
  assign addrByte = {`LNB_ADDR_HIGH, r.addrSel, r.rw};

  // Level the host leaves on the data wire in a slot
  function automatic logic slotBit(input logic [4:0] slot, input logic [7:0] adr,
    input logic [7:0] tx, input logic rd);
    logic bitVal;
    bitVal = 1'b1;
    if (slot < `LNB_ACK_SLOT) begin
      bitVal = adr[3'(7 - slot)];
    end else if (slot > `LNB_ACK_SLOT && slot < `LNB_LAST_SLOT) begin
      bitVal = rd ? 1'b1 : tx[3'(16 - slot)];
    end else if (slot == `LNB_LAST_SLOT) begin
      bitVal = !rd; // Acknowledge a read byte
    end
    return bitVal;
  endfunction

  // Next-state logic
  always_comb begin
    n = r;
    n.sync1 = {bus.sda, bus.scl};
    n.sync2 = r.sync1;
    n.qCnt = qTick ? 16'h0000 : r.qCnt + 16'h0001;

    // Command port writes
    if (regWrite && regAddr == `LNB_HOST_TXDATA) begin
      n.txData = regWdata;
    end
    if (regWrite && regAddr == `LNB_HOST_CMD && !r.busy) begin
      n.rw = regWdata[`LNB_CMD_READ_BIT];
      n.addrSel = regWdata[`LNB_CMD_ADDR_BIT];
      n.phase = H_START;
      n.quarter = 2'h0;
      n.busy = 1'b1;
      n.done = 1'b0;
      n.nack = 1'b0;
    end

    // Command port reads, data one cycle later
    case (regAddr)
      `LNB_HOST_CMD: n.rdata = {6'h00, r.addrSel, r.rw};
      `LNB_HOST_TXDATA: n.rdata = r.txData;
      `LNB_HOST_RXDATA: n.rdata = r.rxData;
      default: n.rdata = {5'h00, r.done, r.nack, r.busy};
    endcase
    if (!regRead) begin
      n.rdata = 8'h00;
    end

    // Bus sequencer, four quarters per bit
    if (qTick && r.phase != H_IDLE) begin
      n.quarter = r.quarter + 2'h1;
      case (r.phase)
        H_START: begin
          case (r.quarter)
            2'h0: begin
              n.sclOe = 1'b0;
              n.sdaOe = 1'b0;
            end
            2'h2: n.sdaOe = 1'b1; // R18
            2'h3: begin
              n.sclOe = 1'b1;
              n.phase = H_BIT;
              n.slot = 5'h00;
            end
            default: n.sclOe = 1'b0;
          endcase
        end
        H_BIT: begin
          case (r.quarter)
            2'h0: n.sdaOe = !slotBit(r.slot, addrByte, r.txData, r.rw); // R21 R3
            2'h1: n.sclOe = 1'b0;
            2'h2: begin
              if (r.slot == `LNB_ACK_SLOT && sdaS) begin
                n.nack = 1'b1;
              end else if (r.slot == `LNB_LAST_SLOT && !r.rw && sdaS) begin
                n.nack = 1'b1;
              end else if (r.rw && r.slot > `LNB_ACK_SLOT && r.slot < `LNB_LAST_SLOT) begin
                n.rxData = {r.rxData[6:0], sdaS}; // R21
              end
            end
            default: begin
              n.sclOe = 1'b1;
              if ((r.slot == `LNB_ACK_SLOT && r.nack) || r.slot == `LNB_LAST_SLOT) begin
                n.phase = H_STOP; // R18
              end else begin
                n.slot = r.slot + 5'h01;
              end
            end
          endcase
        end
        H_STOP: begin
          case (r.quarter)
            2'h0: n.sdaOe = 1'b1;
            2'h1: n.sclOe = 1'b0;
            2'h2: n.sdaOe = 1'b0; // R22
            default: begin
              n.phase = H_IDLE; // R22
              n.busy = 1'b0;
              n.done = 1'b1;
            end
          endcase
        end
        default: n.phase = H_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= HOST_RESET;
    end else begin
      r <= n;
    end
  end

  assign regRdata = r.rdata;
  assign bus.hostSclOe = r.sclOe;
  assign bus.hostSdaOe = r.sdaOe;
  assign bus.hostSclOut = 1'b0;
  assign bus.hostSdaOut = 1'b0;
endmodule

// File: verif/lnb_chk.sv
`timescale 1ns/10ps
// Watches the two-wire bus between both ends
module lnb_chk #(
  parameter logic ADDR_SEL = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hostSclOut,
  input wire logic hostSclOe,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  logic sclQ; // Clock wire one cycle ago
  logic sdaQ; // Data wire one cycle ago
  logic [4:0] riseCnt; // Clock rises since last start
  logic [6:0] addrQ; // Address and strap bits seen

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Tracks start and counts clock rises of a transfer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      riseCnt <= 5'h00;
      addrQ <= {6'h04, ADDR_SEL};
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
      if (sclQ && scl && sdaQ && !sda) begin
        riseCnt <= 5'h00;
      end else if (!sclQ && scl) begin
        riseCnt <= riseCnt + 5'h01;
        if (riseCnt < 5'h07) begin
          addrQ <= {addrQ[5:0], sda};
        end
      end
    end
  end

  AST_SCL_ONLY_HOST: assert property (scl == !hostSclOe)
    else $error("clock wire not set by host alone");
  AST_HOST_SCL_LOW: assert property (!hostSclOut)
    else $error("host clock drive value not low");
  AST_SDA_DRIVE_LOW: assert property (!devSdaOut && !hostSdaOut)
    else $error("data drive value not low");
  AST_DEV_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(devSdaOe))
    else $error("device changed data while clock high");
  AST_DEV_QUIET_ADDR: assert property ($rose(scl) && riseCnt < 5'h08 |-> !devSdaOe)
    else $error("device drove data during address byte");
  AST_NO_ACK_FOREIGN: assert property (
    riseCnt >= 5'h08 && addrQ != {6'h04, ADDR_SEL} |-> !devSdaOe)
    else $error("device answered a foreign address");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_ACK_RELEASED: assert property ($rose(devSdaOe) |-> ##[1:1000] !devSdaOe)
    else $error("device held data low too long");
  AST_START_BY_HOST: assert property (scl && $past(scl) && $fell(sda) |-> hostSdaOe)
    else $error("start not made by host");
endmodule

// File: verif/lnb_tb_top.sv
`timescale 1ns/10ps
// Drives the host command port and the supply pins
module lnb_tb_top;
  logic clk; // System clock
  logic resetn; // Async reset, low active
  logic [1:0] regAddr, toneGate, forceHigh, overloadDet; // Port address and pins
  logic [7:0] regWdata, regRdata, rx; // Port data and last read
  logic regWrite, regRead, overTemp, powerGood, softStartDone; // Strobes and pins
  logic [1:0] convOn, voltHigh, cableComp, limitHigh, toneOut, overloadFlag; // Outputs
  logic limitStatic, overheatFlag, nk, seen, strap; // Outputs, scratch, address strap
  int errTotal, numChecks; // Counters
  lnb_if busIf();

  lnb_device #(.TICK_CYCLES(10), .OFF_TICKS(9), .ON_TICKS(2), .TONE_HALF(4)) u_lnb_device (
    .clk(clk), .resetn(resetn), .bus(busIf), .addrSel(strap), .toneGate(toneGate),
    .forceHigh(forceHigh), .overloadDet(overloadDet), .overTemp(overTemp),
    .powerGood(powerGood), .softStartDone(softStartDone), .convOn(convOn),
    .voltHigh(voltHigh), .cableComp(cableComp), .limitHigh(limitHigh), .toneOut(toneOut),
    .limitStatic(limitStatic), .overheatFlag(overheatFlag), .overloadFlag(overloadFlag));
  lnb_host #(.QUARTER_CYCLES(16)) u_lnb_host (.clk(clk), .resetn(resetn), .bus(busIf),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata));
  lnb_chk u_lnb_chk (.clk(clk), .resetn(resetn),
    .hostSclOut(busIf.hostSclOut), .hostSclOe(busIf.hostSclOe),
    .hostSdaOut(busIf.hostSdaOut), .hostSdaOe(busIf.hostSdaOe), .devSdaOut(busIf.devSdaOut),
    .devSdaOe(busIf.devSdaOe), .scl(busIf.scl), .sda(busIf.sda));

  // Free-running system clock
  always #10 clk = ~clk;

  // Prints counts and verdict, ends the run
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compares one value against its expectation
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits whole cycles, then settles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle write strobe on the command port
  task automatic hw(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // One-cycle read strobe; data taken in the following cycle
  task automatic hr(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  // One whole bus transfer, polled to completion
  task automatic xfer(input logic rd, input logic sel, input logic [7:0] tx,
      output logic nack, output logic [7:0] got);
    logic [7:0] st;
    st = 8'h01;
    hw(2'h1, tx);
    hw(2'h0, {6'h00, sel, rd});
    for (int n = 0; n < 2000 && st[0] !== 1'b0; n++) begin
      hr(2'h3, st);
    end
    if (st[0] !== 1'b0) begin
      errTotal++;
      $display("CHECK FAILED at %0t: transfer hung", $time);
      summarize();
    end
    nack = st[1];
    hr(2'h2, got);
  endtask

  // Register write and read to the matching address
  task automatic wr(input logic [7:0] d);
    xfer(1'b0, 1'b1, d, nk, rx);
    chk({7'h00, nk}, 8'h00);
  endtask
  task automatic rdreg();
    xfer(1'b1, 1'b1, 8'h00, nk, rx);
    chk({7'h00, nk}, 8'h00);
  endtask

  // Reports whether a tone output toggles
  task automatic tog(input int i);
    logic first;
    first = toneOut[i];
    seen = 1'b0;
    repeat (24) begin
      cyc(1);
      seen = seen | (toneOut[i] !== first);
    end
  endtask

  // Bounded wait for channel one converter level
  task automatic waitOn(input logic v);
    for (int n = 0; n < 300 && convOn[0] !== v; n++) begin
      cyc(1);
    end
    chk({7'h00, convOn[0]}, {7'h00, v});
    if (convOn[0] !== v) begin
      summarize();
    end
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {regAddr, regWdata, regWrite, regRead} = '0;
    {toneGate, forceHigh, overloadDet, overTemp, softStartDone} = '0;
    powerGood = 1'b1;
    strap = 1'b1;
    errTotal = 0;
    numChecks = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    cyc(8);
    chk({convOn, voltHigh, toneOut, overloadFlag}, 8'h00);
    rdreg();
    chk(rx, 8'h00);
    wr(8'h7f);
    rdreg();
    chk(rx, 8'h7e);
    chk({2'h0, limitStatic, limitHigh[0], cableComp[0], voltHigh[0], convOn}, 8'h3d);
    tog(0);
    chk({7'h00, seen}, 8'h01);
    wr(8'hff);
    rdreg();
    chk(rx, 8'hfc);
    chk({3'h0, limitHigh[1], cableComp[1], voltHigh[1], convOn}, 8'h1f);
    tog(1);
    chk({7'h00, seen}, 8'h01);
    wr(8'h80);
    chk({6'h00, convOn}, 8'h01);
    wr(8'h02);
    cyc(6);
    tog(0);
    chk({7'h00, seen}, 8'h00);
    @(posedge clk) toneGate <= 2'b01;
    tog(0);
    chk({7'h00, seen}, 8'h01);
    @(posedge clk) forceHigh <= 2'b01;
    cyc(6);
    chk({6'h00, voltHigh}, 8'h01);
    @(posedge clk) forceHigh <= 2'b00;
    wr(8'h42);
    @(posedge clk) overloadDet <= 2'b01;
    cyc(6);
    chk({4'h0, overloadFlag, convOn}, 8'h05);
    rdreg();
    chk(rx, 8'h43);
    @(posedge clk) overloadDet <= 2'b00;
    cyc(6);
    chk({6'h00, overloadFlag}, 8'h00);
    wr(8'h02);
    @(posedge clk) overloadDet <= 2'b01;
    cyc(6);
    chk({4'h0, overloadFlag, convOn}, 8'h04);
    waitOn(1'b1);
    chk({6'h00, overloadFlag}, 8'h01);
    waitOn(1'b0);
    @(posedge clk) overloadDet <= 2'b00;
    waitOn(1'b1);
    cyc(40);
    chk({4'h0, overloadFlag, convOn}, 8'h01);
    @(posedge clk) overloadDet <= 2'b01;
    cyc(6);
    @(posedge clk) softStartDone <= 1'b1;
    cyc(6);
    chk({6'h00, overloadFlag}, 8'h00);
    @(posedge clk) overloadDet <= 2'b00;
    waitOn(1'b1);
    @(posedge clk) overTemp <= 1'b1;
    cyc(6);
    chk({5'h00, overheatFlag, convOn}, 8'h04);
    @(posedge clk) overTemp <= 1'b0;
    cyc(6);
    chk({5'h00, overheatFlag, convOn}, 8'h00);
    rdreg();
    chk(rx, 8'h00);
    @(posedge clk) powerGood <= 1'b0;
    cyc(6);
    xfer(1'b0, 1'b1, 8'h02, nk, rx);
    chk({7'h00, nk}, 8'h01);
    @(posedge clk) powerGood <= 1'b1;
    cyc(6);
    xfer(1'b0, 1'b0, 8'h02, nk, rx);
    chk({6'h00, nk, convOn[0]}, 8'h02);
    summarize();
  end
endmodule
